// *** rtl/dcc_pkg.sv ***
// constants, field layout and state codes of the dma chain control channel
package dcc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_SRC_ADDR = 8'h00;
  localparam logic [7:0] OFF_DST_ADDR = 8'h04;
  localparam logic [7:0] OFF_NEXT_PTR = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_SETUP = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // control word fields
  localparam int CTRL_IRQ_EN = 31;
  localparam int CTRL_DST_STEP = 27;
  localparam int CTRL_SRC_STEP = 26;
  localparam int CTRL_DW_LSB = 21;
  localparam int CTRL_SW_LSB = 18;
  localparam int CTRL_DRUN_LSB = 15;
  localparam int CTRL_SRUN_LSB = 12;
  localparam int CTRL_CNT_LSB = 0;
  localparam int CNT_W = 12;
  localparam int PTR_LSB = 2;
  // chan_setup_reg fields
  localparam int SETUP_EN = 0;
  localparam int SETUP_GATE = 1;
  // interrupt status fields
  localparam int STAT_DONE = 0;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // descriptor layout: four words
  localparam logic [1:0] DESC_LAST = 2'h3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_READ = 3'b001,
    S_WRITE = 3'b010,
    S_FETCH = 3'b011,
    S_YIELD = 3'b100
  } dcc_state_type;
endpackage : dcc_pkg

// *** rtl/dcc_addr_step.sv ***
// address stepper: advances an address by the access width when stepping is on
`timescale 1ns/1ps
module dcc_addr_step (
  input wire logic [31:0] addr,
  input wire logic [2:0] width,
  input wire logic step,
  output logic [31:0] next_addr
);
  wire [31:0] incr;
  // reserved width codes fall back to a word step; software must not use them
  assign incr = (width == 3'b000) ? 32'h0000_0001 :
                (width == 3'b001) ? 32'h0000_0002 : 32'h0000_0004;
  assign next_addr = step ? addr + incr : addr;
endmodule : dcc_addr_step

// *** rtl/dcc_channel.sv ***
// one dma channel: descriptor chaining, control word, apb registers, data mover
// Behaviour
// - link register bits 31..2 hold the next descriptor word address
// - zero link pointer ends the chain; channel disables, no further fetch
// - end interrupt only when control bit 31 and setup gate both set
// - control bit 27 set advances destination after each write, else fixed
// - control bit 26 set advances source after each read, else fixed
// - bits 23..21 give destination width: byte, halfword, word
// - bits 20..18 give source width with the same codes
// - bits 17..15 give destination run length 1,4,8..256 beats
// - bits 14..12 give source run length with the same mapping
// - run lengths only size internal requests, not bus burst types
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module dcc_channel (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] run_beats(input logic [2:0] code);
    run_beats = (code == 3'b000) ? 9'h001 : 9'((9'h002) << code);
  endfunction : run_beats

  ////////////////////////////////////////////////////////////////////////////////
  dcc_pkg::dcc_state_type state_q, state_d;
  logic [31:0] src_q, dst_q, lli_q, ctrl_q, data_q, prdata_q;
  logic en_q, gate_q, stat_q, mask_q, irq_q, pready_q, pslverr_q;
  logic req_q, we_q;
  logic [31:0] maddr_q;
  logic [1:0] msize_q;
  logic [8:0] srun_q, drun_q;
  logic [1:0] fidx_q;

  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite & pready_q;
  wire hit_src = paddr == dcc_pkg::OFF_SRC_ADDR;
  wire hit_dst = paddr == dcc_pkg::OFF_DST_ADDR;
  wire hit_lli = paddr == dcc_pkg::OFF_NEXT_PTR;
  wire hit_ctl = paddr == dcc_pkg::OFF_CTRL;
  wire hit_set = paddr == dcc_pkg::OFF_SETUP;
  wire hit_sta = paddr == dcc_pkg::OFF_IRQ_STAT;
  wire hit_msk = paddr == dcc_pkg::OFF_IRQ_MASK;
  wire mapped = hit_src | hit_dst | hit_lli | hit_ctl | hit_set | hit_sta | hit_msk;
  wire [31:0] rd_mux = hit_src ? src_q : hit_dst ? dst_q : hit_lli ? lli_q :
                       hit_ctl ? ctrl_q :
                       hit_set ? {30'h0000_0000, gate_q, en_q} :
                       hit_sta ? {31'h0000_0000, stat_q} :
                       hit_msk ? {31'h0000_0000, mask_q} : dcc_pkg::RST_WORD;

  // control word fields
  wire [2:0] dw = ctrl_q[dcc_pkg::CTRL_DW_LSB +: 3];
  wire [2:0] sw = ctrl_q[dcc_pkg::CTRL_SW_LSB +: 3];
  wire [dcc_pkg::CNT_W-1:0] cnt = ctrl_q[dcc_pkg::CTRL_CNT_LSB +: dcc_pkg::CNT_W];
  wire [29:0] link = lli_q[31:dcc_pkg::PTR_LSB];
  wire chain_end = link == 30'h0000_0000;
  wire [31:0] src_nx, dst_nx;

  dcc_addr_step u_src_step (
    .addr(src_q),
    .width(sw),
    .step(ctrl_q[dcc_pkg::CTRL_SRC_STEP]),
    .next_addr(src_nx)
  );
  dcc_addr_step u_dst_step (
    .addr(dst_q),
    .width(dw),
    .step(ctrl_q[dcc_pkg::CTRL_DST_STEP]),
    .next_addr(dst_nx)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // engine events
  wire rd_done = (state_q == dcc_pkg::S_READ) & mem_ack;
  wire wr_done = (state_q == dcc_pkg::S_WRITE) & mem_ack;
  wire fetch_ack = (state_q == dcc_pkg::S_FETCH) & mem_ack;
  wire fetch_last = fetch_ack & (fidx_q == dcc_pkg::DESC_LAST);
  wire cnt_last = cnt == 12'h001;
  // a descriptor completes when its last beat is written or it starts with count zero
  wire start_zero = (state_q == dcc_pkg::S_IDLE) & en_q & (cnt == 12'h000);
  wire xfer_end = (wr_done & cnt_last) | start_zero;
  wire end_irq = xfer_end & ctrl_q[dcc_pkg::CTRL_IRQ_EN] & gate_q;
  // the source count drops at each read, so it is spent at zero by the time its write ends
  wire run_out = (srun_q == 9'h000) | (drun_q == 9'h001);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dcc_pkg::S_IDLE:
        if (en_q & (cnt != 12'h000))
          state_d = dcc_pkg::S_READ;
        else if (start_zero & ~chain_end)
          state_d = dcc_pkg::S_FETCH;
      dcc_pkg::S_READ:
        if (mem_ack)
          state_d = dcc_pkg::S_WRITE;
      dcc_pkg::S_WRITE:
        if (mem_ack)
        begin
          if (cnt_last)
            state_d = chain_end ? dcc_pkg::S_IDLE : dcc_pkg::S_FETCH;
          else if (run_out)
            state_d = dcc_pkg::S_YIELD;
          else
            state_d = dcc_pkg::S_READ;
        end
      dcc_pkg::S_FETCH:
        if (fetch_last)
          state_d = dcc_pkg::S_IDLE;
      dcc_pkg::S_YIELD:
        state_d = dcc_pkg::S_READ;
      default:
        state_d = dcc_pkg::S_IDLE;
    endcase
  end

  // memory request for the next state, taken from current values
  wire [31:0] fetch_base = {link, 2'b00};
  wire next_req = (state_d == dcc_pkg::S_READ) | (state_d == dcc_pkg::S_WRITE) |
                  (state_d == dcc_pkg::S_FETCH);
  wire [1:0] fidx_d = (state_q != dcc_pkg::S_FETCH) ? 2'b00 : fidx_q + 2'(fetch_ack);
  // the source register has already stepped at the read, and a fetch steps its own
  // last address because the link register is reloaded before the final word
  wire [31:0] addr_d = (state_d == dcc_pkg::S_READ) ? src_q :
                       (state_d == dcc_pkg::S_WRITE) ? dst_q :
                       (state_q == dcc_pkg::S_FETCH) ?
                       maddr_q + (fetch_ack ? 32'h0000_0004 : 32'h0000_0000) :
                       fetch_base;
  wire [1:0] size_d = (state_d == dcc_pkg::S_WRITE) ? dw[1:0] :
                      (state_d == dcc_pkg::S_READ) ? sw[1:0] : 2'b10;

  ////////////////////////////////////////////////////////////////////////////////
  // register next values: the engine owns the source, destination, link and control registers while it moves data
  wire busy = state_q != dcc_pkg::S_IDLE;
  wire w_src = wr_acc & hit_src & ~busy;
  wire w_dst = wr_acc & hit_dst & ~busy;
  wire w_lli = wr_acc & hit_lli & ~busy;
  wire w_ctl = wr_acc & hit_ctl & ~busy;
  wire [31:0] src_d = (fetch_ack & fidx_q == 2'd0) ? mem_rdata :
                      rd_done ? src_nx : w_src ? pwdata : src_q;
  wire [31:0] dst_d = (fetch_ack & fidx_q == 2'd1) ? mem_rdata :
                      wr_done ? dst_nx : w_dst ? pwdata : dst_q;
  // all 32 bits are stored so reserved and low pointer bits read back as written
  wire [31:0] lli_d = (fetch_ack & fidx_q == 2'd2) ? mem_rdata : w_lli ? pwdata : lli_q;
  wire [31:0] ctrl_d = (fetch_ack & fidx_q == 2'd3) ? mem_rdata :
                       wr_done ? {ctrl_q[31:dcc_pkg::CNT_W], cnt - 12'h001} :
                       w_ctl ? pwdata : ctrl_q;
  // a chain that ends clears the enable; the clear beats a same-cycle software set
  wire en_d = (xfer_end & chain_end) ? 1'b0 :
              (wr_acc & hit_set) ? pwdata[dcc_pkg::SETUP_EN] : en_q;
  wire stat_d = end_irq | (stat_q & ~(wr_acc & hit_sta & pwdata[dcc_pkg::STAT_DONE]));
  wire [8:0] srun_d = (state_q == dcc_pkg::S_IDLE) | (state_d == dcc_pkg::S_YIELD) |
                      (state_q == dcc_pkg::S_FETCH) ?
                      run_beats(ctrl_d[dcc_pkg::CTRL_SRUN_LSB +: 3]) :
                      srun_q - 9'(rd_done);
  wire [8:0] drun_d = (state_q == dcc_pkg::S_IDLE) | (state_d == dcc_pkg::S_YIELD) |
                      (state_q == dcc_pkg::S_FETCH) ?
                      run_beats(ctrl_d[dcc_pkg::CTRL_DRUN_LSB +: 3]) :
                      drun_q - 9'(wr_done);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= dcc_pkg::S_IDLE;
      src_q <= dcc_pkg::RST_WORD;
      dst_q <= dcc_pkg::RST_WORD;
      lli_q <= dcc_pkg::RST_WORD;
      ctrl_q <= dcc_pkg::RST_WORD;
      data_q <= dcc_pkg::RST_WORD;
      en_q <= 1'b0;
      gate_q <= 1'b0;
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      srun_q <= 9'h001;
      drun_q <= 9'h001;
      fidx_q <= 2'b00;
    end
    else
    begin
      state_q <= state_d;
      src_q <= src_d;
      dst_q <= dst_d;
      lli_q <= lli_d;
      ctrl_q <= ctrl_d;
      data_q <= rd_done ? mem_rdata : data_q;
      en_q <= en_d;
      gate_q <= (wr_acc & hit_set) ? pwdata[dcc_pkg::SETUP_GATE] : gate_q;
      stat_q <= stat_d;
      mask_q <= (wr_acc & hit_msk) ? pwdata[dcc_pkg::STAT_DONE] : mask_q;
      srun_q <= srun_d;
      drun_q <= drun_d;
      fidx_q <= fidx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      maddr_q <= dcc_pkg::RST_WORD;
      msize_q <= 2'b00;
      prdata_q <= dcc_pkg::RST_WORD;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      req_q <= next_req;
      we_q <= state_d == dcc_pkg::S_WRITE;
      maddr_q <= addr_d;
      msize_q <= size_d;
      prdata_q <= setup_ph ? rd_mux : prdata_q;
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      irq_q <= stat_d & mask_q;
    end
  end

  assign mem_req = req_q;
  assign mem_we = we_q;
  assign mem_addr = maddr_q;
  assign mem_size = msize_q;
  assign mem_wdata = data_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  a_last_disables: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_end & chain_end) |=> !en_q && state_q == dcc_pkg::S_IDLE)
    else $error("chain end did not disable channel");
  a_no_fetch_last: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_end & chain_end) |=> !mem_req)
    else $error("fetch issued after last descriptor");
  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(stat_q) |-> $past(ctrl_q[dcc_pkg::CTRL_IRQ_EN]) && $past(gate_q))
    else $error("end interrupt without both enables");
  a_dst_step: assert property (@(posedge pclk) disable iff (!presetn)
    wr_done && !cnt_last |=> dst_q == $past(dst_q) +
      ($past(ctrl_q[dcc_pkg::CTRL_DST_STEP]) ? 32'h0000_0001 << $past(dw) : 32'h0000_0000))
    else $error("destination address step wrong");
  a_src_step: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && ctrl_q[dcc_pkg::CTRL_SRC_STEP] |=>
      src_q == $past(src_q) + (32'h0000_0001 << $past(sw)))
    else $error("source address step wrong");
  a_src_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done && !ctrl_q[dcc_pkg::CTRL_SRC_STEP] |=> src_q == $past(src_q))
    else $error("fixed source address moved");
  a_wr_size: assert property (@(posedge pclk) disable iff (!presetn)
    rd_done |=> mem_we && mem_size == dw[1:0])
    else $error("write size not destination width");
  a_rd_size: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_req && !mem_we && state_q == dcc_pkg::S_READ) |-> mem_size == sw[1:0])
    else $error("read size not source width");
  a_run_yield: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && !cnt_last && drun_q == 9'h001) |=> !mem_req ##1 mem_req)
    else $error("destination run did not yield once");
  a_fetch_words: assert property (@(posedge pclk) disable iff (!presetn)
    (xfer_end && !chain_end) |=> mem_req && !mem_we && mem_addr == $past(fetch_base))
    else $error("descriptor fetch address wrong");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    irq |-> $past(stat_d) && $past(mask_q))
    else $error("interrupt without masked status");
  a_src_yield: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_done && !cnt_last && srun_q == 9'h000) |=> !mem_req ##1 mem_req)
    else $error("source run did not yield once");
  a_fetch_step: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_ack && !fetch_last |=> mem_req && mem_addr == $past(mem_addr) + 32'h0000_0004)
    else $error("descriptor word address wrong");
  a_req_stable: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_size))
    else $error("memory request changed before its answer");
  a_end_stat: assert property (@(posedge pclk) disable iff (!presetn)
    xfer_end && ctrl_q[dcc_pkg::CTRL_IRQ_EN] && gate_q |=> stat_q)
    else $error("enabled transfer end left status clear");
  a_pready_once: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("register answer longer than one cycle");
endmodule : dcc_channel

// *** sim/dcc_mem_model.sv ***
// behavioural word memory on the far side of the channel memory port
`timescale 1ns/1ps
module dcc_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic [3:0] wait_q;
  logic [31:0] waddr;
  logic [1:0] wsize, rsize;
  int n_wr;
  // one idle cycle after each ack, so a stale request is never taken twice
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'hA5A5_5A5A;
      wait_q <= 4'h0;
      n_wr <= 0;
    end
    else if (mem_ack)
    begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      // read data is not left valid past its ack
      mem_rdata <= ~mem_rdata;
    end
    else if (mem_req && wait_q >= lat)
    begin
      mem_ack <= 1'b1;
      if (mem_we)
      begin
        mem[mem_addr[7:2]] <= mem_wdata;
        waddr <= mem_addr;
        wsize <= mem_size;
        n_wr <= n_wr + 1;
      end
      else
      begin
        mem_rdata <= mem[mem_addr[7:2]];
        rsize <= mem_size;
      end
    end
    else if (mem_req)
      wait_q <= wait_q + 4'h1;
endmodule : dcc_mem_model

// *** sim/dma_channel_chain_control_tb.sv ***
// self-checking bench of the dma chain control channel
`timescale 1ns/1ps
module dma_channel_chain_control_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] lat = 4'h1;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rd;
  logic pready, pslverr, mem_req, mem_we, mem_ack, irq, err;
  logic [1:0] mem_size;
  int n_errors = 0;
  int comparisons = 0;
  always #5 pclk = ~pclk;
  dcc_channel u_dcc_channel (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_size, .mem_wdata,
    .mem_ack, .mem_rdata, .irq);
  dcc_mem_model u_dcc_mem_model (.pclk, .presetn, .mem_req, .mem_we, .mem_addr,
    .mem_size, .mem_wdata, .lat, .mem_ack, .mem_rdata);
  //////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic hang(input string what);
    n_errors++;
    $display("mismatch %s expected done seen timeout", what);
    conclude();
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && n++ < 20);
    if (pready !== 1'b1) hang("apb answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    cmp(what, exp, rd);
  endtask : rdc
  // control goes in before the enable write, and the end is seen by polling
  task automatic run(input logic [31:0] s, d, l, c, e);
    int n = 0;
    apb(1'b1, 8'h00, s);
    apb(1'b1, 8'h04, d);
    apb(1'b1, 8'h08, l);
    apb(1'b1, 8'h0C, c);
    apb(1'b1, 8'h10, e);
    do
      apb(1'b0, 8'h10, 32'h0000_0000);
    while (rd[0] !== 1'b0 && n++ < 200);
    if (rd[0] !== 1'b0) hang("channel stop");
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    for (int a = 0; a < 7; a++)
      rdc(8'(4 * a), 32'h0000_0000, "reset word");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    cmp("unmapped error", 32'h0000_0001, {31'h0, err});
    cmp("unmapped read", 32'h0000_0000, rd);
    apb(1'b1, 8'h08, 32'hFFFF_FFEF);
    rdc(8'h08, 32'hFFFF_FFEF, "link word");
    apb(1'b1, 8'h0C, 32'h7300_0000);
    rdc(8'h0C, 32'h7300_0000, "reserved bits");
  endtask : t_regs
  task automatic t_single;
    int n0 = u_dcc_mem_model.n_wr;
    u_dcc_mem_model.mem[8] = 32'h1111_2222;
    u_dcc_mem_model.mem[9] = 32'h3333_4444;
    u_dcc_mem_model.mem[10] = 32'h5555_6666;
    u_dcc_mem_model.mem[11] = 32'h7777_8888;
    apb(1'b1, 8'h18, 32'h0000_0001);
    run(32'h0000_0020, 32'h0000_0080, 32'h0000_0000, 32'h8C48_0002, 32'h0000_0003);
    cmp("first word", 32'h1111_2222, u_dcc_mem_model.mem[32]);
    cmp("second word", 32'h3333_4444, u_dcc_mem_model.mem[33]);
    cmp("write count", 32'h0000_0002, 32'(u_dcc_mem_model.n_wr - n0));
    cmp("word size", 32'h0000_0002, {30'h0, u_dcc_mem_model.wsize});
    rdc(8'h10, 32'h0000_0002, "setup after end");
    rdc(8'h14, 32'h0000_0001, "end status");
    cmp("irq level", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, 8'h14, 32'h0000_0001);
    rdc(8'h14, 32'h0000_0000, "cleared status");
    cmp("irq cleared", 32'h0000_0000, {31'h0, irq});
  endtask : t_single
  task automatic t_chain;
    int n0 = u_dcc_mem_model.n_wr;
    u_dcc_mem_model.mem[16] = 32'h0000_0024;
    u_dcc_mem_model.mem[17] = 32'h0000_0090;
    u_dcc_mem_model.mem[18] = 32'h0000_0000;
    // five beats against a source run of four force one yield mid-descriptor
    u_dcc_mem_model.mem[19] = 32'h8027_9005;
    lat <= 4'h4;
    apb(1'b1, 8'h18, 32'h0000_0000);
    run(32'h0000_0020, 32'h0000_0088, 32'h0000_0040, 32'h0C48_0001, 32'h0000_0003);
    cmp("head word", 32'h1111_2222, u_dcc_mem_model.mem[34]);
    cmp("fixed word", 32'h3333_4444, u_dcc_mem_model.mem[36]);
    cmp("fixed target", 32'h0000_0090, u_dcc_mem_model.waddr);
    cmp("half write", 32'h0000_0001, {30'h0, u_dcc_mem_model.wsize});
    cmp("half read", 32'h0000_0001, {30'h0, u_dcc_mem_model.rsize});
    rdc(8'h00, 32'h0000_0024, "fixed source");
    rdc(8'h04, 32'h0000_0090, "fixed dest");
    rdc(8'h0C, 32'h8027_9000, "loaded control");
    cmp("chain writes", 32'h0000_0006, 32'(u_dcc_mem_model.n_wr - n0));
    rdc(8'h14, 32'h0000_0001, "chain status");
    cmp("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, 8'h14, 32'h0000_0001);
  endtask : t_chain
  task automatic t_gate;
    lat <= 4'h2;
    apb(1'b1, 8'h18, 32'h0000_0001);
    for (int k = 0; k < 2; k++)
    begin
      run(32'h0000_0020, 32'h0000_00A1, 32'h0000_0000, k ? 32'h8000_0001 : 32'h0000_0001,
        k ? 32'h0000_0001 : 32'h0000_0003);
      rdc(8'h14, 32'h0000_0000, "gated status");
      cmp("byte read", 32'h0000_0000, {30'h0, u_dcc_mem_model.rsize});
      cmp("byte target", 32'h0000_00A1, u_dcc_mem_model.waddr);
    end
    cmp("irq gated", 32'h0000_0000, {31'h0, irq});
  endtask : t_gate
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_single();
    t_chain();
    t_gate();
    conclude();
  end
endmodule : dma_channel_chain_control_tb
